// ==== include/pse_pkg.sv ====
// ---------------------------------------------------------------------------
// constants for the press status pulse encoder
// ---------------------------------------------------------------------------
// assumes a 50 mhz system clock and a 32-bit avalon-mm register bus
package pse_pkg;

  // ---------------------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------------------
  localparam int unsigned CLK_HZ         = 50_000_000;
  localparam int unsigned SLOT_MS        = 100;
  localparam int unsigned PERIOD_MS      = 1000;
  localparam int unsigned CAM_TIMEOUT_MS = 3000;
  localparam int unsigned SLOT_CYC       = CLK_HZ / 1000 * SLOT_MS;
  localparam int unsigned CAM_CYC        = CLK_HZ / 1000 * CAM_TIMEOUT_MS;
  localparam logic [3:0]  PERIOD_SLOTS   = 4'(PERIOD_MS / SLOT_MS);

  // ---------------------------------------------------------------------------
  // register offsets (byte addresses)
  // ---------------------------------------------------------------------------
  localparam logic [4:0] ADDR_CTRL     = 5'h00;
  localparam logic [4:0] ADDR_MAP      = 5'h04;
  localparam logic [4:0] ADDR_POL      = 5'h08;
  localparam logic [4:0] ADDR_EVENTS   = 5'h0c;
  localparam logic [4:0] ADDR_IRQ_STS  = 5'h10;
  localparam logic [4:0] ADDR_IRQ_MASK = 5'h14;
  localparam logic [4:0] ADDR_OUTS     = 5'h18;

  // ---------------------------------------------------------------------------
  // field layout and reset values
  // ---------------------------------------------------------------------------
  localparam int unsigned CTRL_CNT_LSB = 0;
  localparam int unsigned CTRL_MUT_BIT = 4;
  localparam int unsigned CTRL_PIP_BIT = 5;
  localparam int unsigned CTRL_MAN_BIT = 6;
  localparam int unsigned CTRL_CAM_BIT = 7;
  localparam logic [1:0]  TERM_CNT_RST = 2'h3;
  localparam logic [3:0]  CFG_RST      = 4'h0;
  localparam logic [27:0] MAP_RST      = 28'hfbe7a65;
  localparam logic [2:0]  POL_RST      = 3'h0;
  localparam logic [6:0]  MASK_RST     = 7'h00;

  // ---------------------------------------------------------------------------
  // display codes and events (event index is also severity)
  // ---------------------------------------------------------------------------
  localparam logic [1:0] CODE_UNUSED = 2'h0;
  localparam logic [1:0] CODE_SOLID  = 2'h1;
  localparam logic [1:0] CODE_TWO    = 2'h2;
  localparam logic [1:0] CODE_THREE  = 2'h3;

  localparam int unsigned NEV       = 7;
  localparam int unsigned NTERM     = 3;
  localparam logic [2:0] EV_READY = 3'h0;
  localparam logic [2:0] EV_WAIT  = 3'h1;
  localparam logic [2:0] EV_SQS   = 3'h2;
  localparam logic [2:0] EV_PIP   = 3'h3;
  localparam logic [2:0] EV_SAFE  = 3'h4;
  localparam logic [2:0] EV_OPF   = 3'h5;
  localparam logic [2:0] EV_SYS   = 3'h6;

  // ---------------------------------------------------------------------------
  // synchronised pin positions
  // ---------------------------------------------------------------------------
  localparam int unsigned NPIN    = 10;
  localparam int unsigned PIN_NM  = 0;
  localparam int unsigned PIN_MUT = 1;
  localparam int unsigned PIN_RST = 2;
  localparam int unsigned PIN_GO  = 3;
  localparam int unsigned PIN_SQS = 4;
  localparam int unsigned PIN_BOS = 5;
  localparam int unsigned PIN_TOS = 6;
  localparam int unsigned PIN_CAM = 7;
  localparam int unsigned PIN_PIP = 8;
  localparam int unsigned PIN_CYC = 9;

endpackage

// ==== core/pse_pattern.sv ====
// ---------------------------------------------------------------------------
// per-terminal pattern generator: solid, two or three 100 ms pulses per second
// ---------------------------------------------------------------------------
// code and restart come registered from the same clock domain
`timescale 1ns/1ps
`default_nettype none
module pse_pattern #(
  parameter int unsigned SLOT_CYC = pse_pkg::SLOT_CYC
) (
  input  wire logic       i_clk_sys,
  input  wire logic       i_rst_b,
  input  wire logic [1:0] i_code,
  input  wire logic       i_restart,
  output logic            o_level
);

  typedef struct packed {
    logic [31:0] cnt;
    logic [3:0]  slot;
    logic        lvl;
  } pse_pat_t;

  pse_pat_t st_ff;
  pse_pat_t nxt_st;

  function automatic logic slot_high(input logic [1:0] code, input logic [3:0] slot);
    unique case (code)
      pse_pkg::CODE_SOLID: slot_high = 1'b1;
      pse_pkg::CODE_TWO:   slot_high = (slot == 4'h0) || (slot == 4'h2);
      pse_pkg::CODE_THREE: slot_high = (slot == 4'h0) || (slot == 4'h2) || (slot == 4'h4);
      default:             slot_high = 1'b0;
    endcase
  endfunction

  always_comb begin
    nxt_st = st_ff;
    if (i_restart) begin
      nxt_st.cnt  = 32'h0;
      nxt_st.slot = 4'h0;
    end else if (st_ff.cnt == 32'(SLOT_CYC - 1)) begin
      nxt_st.cnt  = 32'h0;
      nxt_st.slot = (st_ff.slot == pse_pkg::PERIOD_SLOTS - 4'h1) ? 4'h0 : st_ff.slot + 4'h1;
    end else begin
      nxt_st.cnt = st_ff.cnt + 32'h1;
    end
    nxt_st.lvl = slot_high(i_code, nxt_st.slot);
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign o_level = st_ff.lvl;

  // ---------------------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------------------
  restart_zero_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
    i_restart |=> (st_ff.cnt == 32'h0) && (st_ff.slot == 4'h0))
    else $error("pattern did not restart");
  two_gap_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
    (i_code == pse_pkg::CODE_TWO) && $stable(i_code) && (st_ff.slot inside {4'h1, 4'h3})
    |-> !o_level)
    else $error("two-pulse gap not low");
  three_pulse_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
    (i_code == pse_pkg::CODE_THREE) && $stable(i_code) && (st_ff.slot == 4'h4) |-> o_level)
    else $error("third pulse missing");
  period_wrap_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
    (st_ff.slot == 4'h9) && (st_ff.cnt == 32'(SLOT_CYC - 1)) && !i_restart
    |=> st_ff.slot == 4'h0)
    else $error("period not ten slots");
  three_cv: cover property (@(posedge i_clk_sys) disable iff (!i_rst_b)
    (i_code == pse_pkg::CODE_THREE) && (st_ff.slot == 4'h4) && o_level);

endmodule
`default_nettype wire

// ==== core/pse_encoder.sv ====
// ---------------------------------------------------------------------------
// press status pulse encoder: press events onto up to three status terminals
// ---------------------------------------------------------------------------
// press pins are asynchronous and synchronised here; running and system
// fault come from controller logic on the same clock; avalon-mm slave.
//
// Functional notes
// - seven events: reset wait, ready/run, seq stop, part alert, safety stop, faults
// - one to three terminals; each terminal may carry any number of the seven events
// - each event per terminal: unused, solid, two pulses or three pulses
// - two pulses: 100 ms high, 100 ms low, repeating every 1 s
// - three pulses: 100 ms high, 100 ms gaps, repeating every 1 s
// - encoding appears only on physical status terminals, never network outputs
// - default map: t1 wait/ready/part alert, t2 seq/opfault, t3 safety/sysfault
// - three terminals by default, reducible to two or one
// - reset wait once stop inputs are back on and reset is still needed
// - ready/run when stop inputs on and reset, or press running
// - sequence stop when ram reaches the sequence stop point
// - part alert on start while ready with part input off or not recycled
// - safety stop on stop input off, or go low early under manual upstroke
// - operational fault on exclusive inputs together or cam wait over 3 s
// - system fault whenever controller reports one
// - per-terminal polarity: sourcing when active by default, else nonconducting
`timescale 1ns/1ps
`default_nettype none
module pse_encoder #(
  parameter int unsigned SLOT_CYC = pse_pkg::SLOT_CYC,
  parameter int unsigned CAM_CYC  = pse_pkg::CAM_CYC
) (
  input  wire logic        i_clk_sys,
  input  wire logic        i_rst_b,
  // avalon-mm slave
  input  wire logic [4:0]  i_avs_address,
  input  wire logic        i_avs_read,
  input  wire logic        i_avs_write,
  input  wire logic [31:0] i_avs_writedata,
  input  wire logic [3:0]  i_avs_byteenable,
  output logic [31:0]      o_avs_readdata,
  output logic             o_avs_waitrequest,
  // press pins, asynchronous
  input  wire logic        i_safety_stop_nm,
  input  wire logic        i_safety_stop_m,
  input  wire logic        i_reset_btn,
  input  wire logic        i_go,
  input  wire logic        i_sequence_stop_point,
  input  wire logic        i_bottom_of_stroke,
  input  wire logic        i_top_of_stroke,
  input  wire logic        i_cam_monitor_switch,
  input  wire logic        i_part_in_place_input,
  input  wire logic        i_cycle_start,
  // controller logic, same clock
  input  wire logic        i_press_running,
  input  wire logic        i_system_fault,
  // outputs
  output logic [2:0]       o_status_out,
  output logic             o_irq
);

  typedef struct packed {
    logic [9:0]       sync1;
    logic [9:0]       sync2;
    logic [9:0]       prev;
    logic [1:0]       fill;
    logic             ack;
    logic [31:0]      rdata;
    logic [1:0]       term_cnt;
    logic [3:0]       cfg;
    logic [27:0]      map;
    logic [2:0]       pol;
    logic [6:0]       ev;
    logic [6:0]       irq_sts;
    logic [6:0]       irq_mask;
    logic             reset_done;
    logic             safety_latch;
    logic             pip_cycled;
    logic             pip_alert;
    logic             cam_to;
    logic [31:0]      cam_cnt;
    logic [2:0][2:0]  sel;
    logic [2:0]       sel_v;
    logic [2:0][1:0]  code;
    logic [2:0]       restart;
    logic [2:0]       out;
  } pse_state_t;

  localparam pse_state_t ST_RST = '{
    term_cnt: pse_pkg::TERM_CNT_RST,
    cfg:      pse_pkg::CFG_RST,
    map:      pse_pkg::MAP_RST,
    pol:      pse_pkg::POL_RST,
    irq_mask: pse_pkg::MASK_RST,
    default:  '0
  };

  pse_state_t st_ff;
  pse_state_t nxt_st;

  logic [9:0] s;
  logic [9:0] rise;
  logic [9:0] fall;
  logic       mute_ok;
  logic       at_stop;
  logic       wr_now;
  logic       cfg_mut;
  logic       cfg_pip;
  logic       cfg_man;
  logic       cfg_cam;
  logic [2:0] pat_lvl;
  logic [31:0] cur_word;
  logic [31:0] wr_word;

  // ---------------------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------------------
  function automatic logic [1:0] map_term(input logic [27:0] map, input int unsigned e);
    map_term = map[e*4+2 +: 2];
  endfunction

  function automatic logic [1:0] map_code(input logic [27:0] map, input int unsigned e);
    map_code = map[e*4 +: 2];
  endfunction

  // byte-lane merge of a write into an old register word
  function automatic logic [31:0] be_merge(input logic [31:0] old, input logic [31:0] wd,
                                           input logic [3:0] be);
    for (int b = 0; b < 4; b++) begin
      be_merge[b*8 +: 8] = be[b] ? wd[b*8 +: 8] : old[b*8 +: 8];
    end
  endfunction

  // ---------------------------------------------------------------------------
  // pin conditioning
  // ---------------------------------------------------------------------------
  assign s       = st_ff.sync2;
  // no edges until prev holds a real pin level, so leaving reset makes none
  assign rise    = (st_ff.fill == 2'h3) ? (st_ff.sync2 & ~st_ff.prev) : 10'h000;
  assign fall    = (st_ff.fill == 2'h3) ? (~st_ff.sync2 & st_ff.prev) : 10'h000;
  assign cfg_mut = st_ff.cfg[pse_pkg::CTRL_MUT_BIT - 4];
  assign cfg_pip = st_ff.cfg[pse_pkg::CTRL_PIP_BIT - 4];
  assign cfg_man = st_ff.cfg[pse_pkg::CTRL_MAN_BIT - 4];
  assign cfg_cam = st_ff.cfg[pse_pkg::CTRL_CAM_BIT - 4];
  assign mute_ok = s[pse_pkg::PIN_NM] && (!cfg_mut || s[pse_pkg::PIN_MUT]);
  assign at_stop = s[pse_pkg::PIN_SQS] || s[pse_pkg::PIN_BOS] || s[pse_pkg::PIN_TOS];
  // a write lands only on the edge where waitrequest is seen low
  assign wr_now  = i_avs_write && st_ff.ack;

  // ---------------------------------------------------------------------------
  // register word at the bus address; writes merge into it lane by lane
  // ---------------------------------------------------------------------------
  always_comb begin
    unique case (i_avs_address)
      pse_pkg::ADDR_CTRL:     cur_word = {24'h0, st_ff.cfg, 2'h0, st_ff.term_cnt};
      pse_pkg::ADDR_MAP:      cur_word = {4'h0, st_ff.map};
      pse_pkg::ADDR_POL:      cur_word = {29'h0, st_ff.pol};
      pse_pkg::ADDR_EVENTS:   cur_word = {25'h0, st_ff.ev};
      pse_pkg::ADDR_IRQ_STS:  cur_word = {25'h0, st_ff.irq_sts};
      pse_pkg::ADDR_IRQ_MASK: cur_word = {25'h0, st_ff.irq_mask};
      pse_pkg::ADDR_OUTS:     cur_word = {29'h0, st_ff.out};
      default:                cur_word = 32'h0;
    endcase
  end

  assign wr_word = be_merge(cur_word, i_avs_writedata, i_avs_byteenable);

  always_comb begin
    nxt_st       = st_ff;
    nxt_st.sync1 = {i_cycle_start, i_part_in_place_input, i_cam_monitor_switch,
                    i_top_of_stroke, i_bottom_of_stroke, i_sequence_stop_point,
                    i_go, i_reset_btn, i_safety_stop_m, i_safety_stop_nm};
    nxt_st.sync2 = st_ff.sync1;
    nxt_st.prev  = st_ff.sync2;
    nxt_st.fill  = (st_ff.fill == 2'h3) ? 2'h3 : st_ff.fill + 2'h1;

    // -------------------------------------------------------------------------
    // press event conditions
    // -------------------------------------------------------------------------
    if (fall[pse_pkg::PIN_NM] || (cfg_mut && fall[pse_pkg::PIN_MUT]) ||
        (cfg_man && fall[pse_pkg::PIN_GO] && !at_stop)) begin
      nxt_st.safety_latch = 1'b1;
      nxt_st.reset_done   = 1'b0;
    end else if (!mute_ok) begin
      nxt_st.reset_done = 1'b0;
    end else if (rise[pse_pkg::PIN_RST]) begin
      nxt_st.safety_latch = 1'b0;
      nxt_st.reset_done   = 1'b1;
    end

    // part must go off and come back on between cycles
    if (rise[pse_pkg::PIN_PIP]) begin
      nxt_st.pip_cycled = 1'b1;
      nxt_st.pip_alert  = 1'b0;
    end else if (rise[pse_pkg::PIN_CYC]) begin
      if (cfg_pip && mute_ok && st_ff.reset_done &&
          (!s[pse_pkg::PIN_PIP] || !st_ff.pip_cycled)) begin
        nxt_st.pip_alert = 1'b1;
      end else begin
        nxt_st.pip_cycled = 1'b0;
      end
    end
    if (!cfg_pip) begin
      nxt_st.pip_alert = 1'b0;
    end

    // cam must follow sequence stop within the timeout
    if (cfg_cam && s[pse_pkg::PIN_SQS] && !s[pse_pkg::PIN_CAM]) begin
      if (st_ff.cam_cnt > 32'(CAM_CYC)) begin
        nxt_st.cam_to = 1'b1;
      end else begin
        nxt_st.cam_cnt = st_ff.cam_cnt + 32'h1;
      end
    end else begin
      nxt_st.cam_cnt = 32'h0;
    end
    if (!s[pse_pkg::PIN_SQS] || !cfg_cam) begin
      nxt_st.cam_to = 1'b0;
    end

    nxt_st.ev[pse_pkg::EV_READY] = i_press_running || (mute_ok && nxt_st.reset_done);
    nxt_st.ev[pse_pkg::EV_WAIT]  = mute_ok && !nxt_st.reset_done;
    nxt_st.ev[pse_pkg::EV_SQS]   = s[pse_pkg::PIN_SQS];
    nxt_st.ev[pse_pkg::EV_PIP]   = nxt_st.pip_alert;
    nxt_st.ev[pse_pkg::EV_SAFE]  = nxt_st.safety_latch;
    nxt_st.ev[pse_pkg::EV_OPF]   = nxt_st.cam_to ||
      (s[pse_pkg::PIN_TOS] && (s[pse_pkg::PIN_BOS] || s[pse_pkg::PIN_SQS] ||
                               s[pse_pkg::PIN_CAM])) ||
      (s[pse_pkg::PIN_SQS] && s[pse_pkg::PIN_BOS]);
    nxt_st.ev[pse_pkg::EV_SYS]   = i_system_fault;

    // -------------------------------------------------------------------------
    // avalon-mm slave, one wait state
    // -------------------------------------------------------------------------
    nxt_st.ack = (i_avs_read || i_avs_write) && !st_ff.ack;
    if (i_avs_read && !st_ff.ack) begin
      nxt_st.rdata = cur_word;
    end
    if (wr_now && i_avs_address == pse_pkg::ADDR_CTRL) begin
      nxt_st.cfg      = wr_word[pse_pkg::CTRL_MUT_BIT +: 4];
      nxt_st.term_cnt = wr_word[pse_pkg::CTRL_CNT_LSB +: 2];
    end
    if (wr_now && i_avs_address == pse_pkg::ADDR_MAP) begin
      nxt_st.map = wr_word[27:0];
    end
    if (wr_now && i_avs_address == pse_pkg::ADDR_POL) begin
      nxt_st.pol = wr_word[2:0];
    end
    if (wr_now && i_avs_address == pse_pkg::ADDR_IRQ_MASK) begin
      nxt_st.irq_mask = wr_word[6:0];
    end
    // write-one-to-clear; a new event in the same cycle wins
    if (wr_now && i_avs_address == pse_pkg::ADDR_IRQ_STS && i_avs_byteenable[0]) begin
      nxt_st.irq_sts = st_ff.irq_sts & ~i_avs_writedata[6:0];
    end
    nxt_st.irq_sts = nxt_st.irq_sts | (nxt_st.ev & ~st_ff.ev);

    // -------------------------------------------------------------------------
    // terminal selection, ascending scan so the last match is most severe
    // -------------------------------------------------------------------------
    for (int t = 0; t < pse_pkg::NTERM; t++) begin
      nxt_st.sel_v[t] = 1'b0;
      nxt_st.sel[t]   = 3'h0;
      nxt_st.code[t]  = pse_pkg::CODE_UNUSED;
      for (int e = 0; e < pse_pkg::NEV; e++) begin
        if (st_ff.ev[e] && (map_term(st_ff.map, e) == 2'(t + 1)) &&
            (map_code(st_ff.map, e) != pse_pkg::CODE_UNUSED) &&
            (2'(t) < st_ff.term_cnt)) begin
          nxt_st.sel_v[t] = 1'b1;
          nxt_st.sel[t]   = 3'(e);
          nxt_st.code[t]  = map_code(st_ff.map, e);
        end
      end
      nxt_st.restart[t] = (nxt_st.sel_v[t] != st_ff.sel_v[t]) ||
                          (nxt_st.sel[t] != st_ff.sel[t]) ||
                          (nxt_st.code[t] != st_ff.code[t]);
    end

    // sourcing when active drives high; nonconducting when active drives low
    nxt_st.out = pat_lvl ^ st_ff.pol;
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      st_ff <= ST_RST;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // ---------------------------------------------------------------------------
  // pattern generators, one per terminal
  // ---------------------------------------------------------------------------
  for (genvar g = 0; g < pse_pkg::NTERM; g++) begin : g_term
    pse_pattern #(
      .SLOT_CYC (SLOT_CYC)
    ) u_pat (
      .i_clk_sys (i_clk_sys),
      .i_rst_b   (i_rst_b),
      .i_code    (st_ff.code[g]),
      .i_restart (st_ff.restart[g]),
      .o_level   (pat_lvl[g])
    );
  end

  assign o_status_out      = st_ff.out;
  assign o_avs_readdata    = st_ff.rdata;
  assign o_avs_waitrequest = (i_avs_read || i_avs_write) && !st_ff.ack;
  assign o_irq             = |(st_ff.irq_sts & st_ff.irq_mask);

  // ---------------------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------------------
  default clocking cb @(posedge i_clk_sys);
  endclocking
  default disable iff (!i_rst_b);

  sys_fault_a: assert property (i_system_fault |=> st_ff.ev[pse_pkg::EV_SYS])
    else $error("system fault event missing");
  seq_stop_a: assert property (s[pse_pkg::PIN_SQS] |=> st_ff.ev[pse_pkg::EV_SQS])
    else $error("sequence stop event missing");
  excl_fault_a: assert property (
    s[pse_pkg::PIN_TOS] && s[pse_pkg::PIN_BOS] |=> st_ff.ev[pse_pkg::EV_OPF])
    else $error("exclusive inputs not flagged");
  stop_latch_a: assert property (
    $fell(s[pse_pkg::PIN_NM]) |=> st_ff.ev[pse_pkg::EV_SAFE] && !st_ff.ev[pse_pkg::EV_READY]
                                  || i_press_running)
    else $error("safety stop not latched");
  running_a: assert property (i_press_running |=> st_ff.ev[pse_pkg::EV_READY])
    else $error("running not shown as ready");
  reset_wait_a: assert property (
    mute_ok && !st_ff.reset_done && !rise[pse_pkg::PIN_RST] |=> st_ff.ev[pse_pkg::EV_WAIT])
    else $error("reset wait event missing");
  severity_sel_a: assert property (
    st_ff.ev[pse_pkg::EV_SYS] && (map_term(st_ff.map, 6) == 2'h3) &&
    (map_code(st_ff.map, 6) != pse_pkg::CODE_UNUSED) && (st_ff.term_cnt == 2'h3)
    |=> st_ff.sel_v[2] && (st_ff.sel[2] == pse_pkg::EV_SYS))
    else $error("lower severity shown");
  term_off_a: assert property (
    ((st_ff.term_cnt == 2'h1) && $stable(st_ff.pol))[*4] |-> st_ff.out[2] == st_ff.pol[2])
    else $error("disabled terminal not idle");
  default_map_a: assert property (@(posedge i_clk_sys) disable iff (1'b0)
    $rose(i_rst_b) |-> (st_ff.map == pse_pkg::MAP_RST) && (st_ff.term_cnt == 2'h3))
    else $error("default mapping wrong after reset");

  restart_cv: cover property (st_ff.restart[0] && st_ff.sel_v[0]);
  irq_cv:     cover property ($rose(o_irq));
  pip_cv:     cover property ($rose(st_ff.ev[pse_pkg::EV_PIP]));

endmodule
`default_nettype wire

// ==== testbench/pse_lamp.sv ====
// ---------------------------------------------------------------------------
// lamp / plc input model: counts rising edges per status terminal
// ---------------------------------------------------------------------------
// assumes terminal levels are registered on the system clock
`timescale 1ns/1ps
`default_nettype none
module pse_lamp (
  input  wire logic       i_clk_sys,
  input  wire logic       i_clr,
  input  wire logic [2:0] i_lamp,
  output logic [11:0]     o_edges
);
  logic [2:0] prev_ff;
  always_ff @(posedge i_clk_sys) begin
    prev_ff <= i_lamp;
    for (int t = 0; t < 3; t++) begin
      if (i_clr) o_edges[4*t +: 4] <= 4'h0;
      else if (i_lamp[t] && !prev_ff[t]) o_edges[4*t +: 4] <= o_edges[4*t +: 4] + 4'h1;
    end
  end
endmodule
`default_nettype wire

// ==== testbench/test_pse_encoder.sv ====
// ---------------------------------------------------------------------------
// self-checking bench for the press status pulse encoder
// ---------------------------------------------------------------------------
// short slots (10 cycles) so a pattern period is 100 cycles
`timescale 1ns/1ps
`default_nettype none
module test_pse_encoder;
  logic clk = 0, rst_b = 0, rd = 0, wr = 0, clr = 0, sf = 0, run = 0, rbtn = 0;
  logic sequence_stop_point = 0, bottom_of_stroke = 0, top_of_stroke = 0, cam = 0, nm = 1, part_in_place_input = 0, cyc = 0;
  logic [4:0] adr = 5'h00;
  logic [31:0] wd = 32'h0, rdat, q;
  logic [31:0] seed = 32'h8d87fc62;
  logic wrq, irq;
  logic [2:0] outs;
  logic [11:0] edges;
  int n_errors = 0, total_checks = 0;
  always #10 clk = ~clk;
  pse_encoder #(.SLOT_CYC(10), .CAM_CYC(50)) pse_encoder_inst (.i_clk_sys(clk), .i_rst_b(rst_b),
    .i_avs_address(adr), .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wd),
    .i_avs_byteenable(4'hf), .o_avs_readdata(rdat), .o_avs_waitrequest(wrq),
    .i_safety_stop_nm(nm), .i_safety_stop_m(1'b1), .i_reset_btn(rbtn), .i_go(1'b0),
    .i_sequence_stop_point(sequence_stop_point), .i_bottom_of_stroke(bottom_of_stroke), .i_top_of_stroke(top_of_stroke),
    .i_cam_monitor_switch(cam), .i_part_in_place_input(part_in_place_input), .i_cycle_start(cyc),
    .i_press_running(run), .i_system_fault(sf), .o_status_out(outs), .o_irq(irq));
  pse_lamp pse_lamp_inst (.i_clk_sys(clk), .i_clr(clr), .i_lamp(outs), .o_edges(edges));
  task automatic final_report();
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // request held until waitrequest seen low at a rising edge
  task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
    logic busy;
    int n;
    n = 0;
    rd <= !w; wr <= w; adr <= a; wd <= d;
    do begin
      @(posedge clk);
      n++;
      busy = wrq;
      q = rdat;
    end while (busy && n < 50);
    rd <= 1'b0; wr <= 1'b0;
    // one idle edge so the next call never re-raises a strobe in this step
    @(posedge clk);
    if (busy) begin n_errors++; final_report(); end
  endtask
  // one full pattern period after settling
  task automatic meas(input logic [11:0] exp);
    repeat (20) @(posedge clk);
    clr <= 1'b1;
    @(posedge clk) clr <= 1'b0;
    repeat (101) @(posedge clk);
    chk(32'(edges), 32'(exp));
  endtask
  initial begin
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    bus(0, pse_pkg::ADDR_CTRL, 0); chk(q, 32'h3);
    bus(0, pse_pkg::ADDR_MAP, 0); chk(q, 32'h0fbe7a65);
    bus(0, pse_pkg::ADDR_POL, 0); chk(q, 32'h0);
    bus(0, 5'h1c, 0); chk(q, 32'h0);
    meas(12'h002);
    sf <= 1'b1;
    meas(12'h302);
    rbtn <= 1'b1; repeat (5) @(posedge clk); rbtn <= 1'b0;
    meas(12'h300); chk(32'(outs[0]), 32'h1);
    sequence_stop_point <= 1'b1;
    meas(12'h320);
    bus(1, pse_pkg::ADDR_CTRL, 32'h83); repeat (60) @(posedge clk);
    meas(12'h330);
    bottom_of_stroke <= 1'b1; top_of_stroke <= 1'b1; run <= 1'b1; cam <= 1'b1;
    meas(12'h330);
    bus(0, pse_pkg::ADDR_EVENTS, 0); chk(q, 32'h65);
    bus(1, pse_pkg::ADDR_IRQ_MASK, 32'h40);
    @(posedge clk) chk(32'(irq), 32'h1);
    bus(1, pse_pkg::ADDR_IRQ_STS, 32'h40);
    @(posedge clk) chk(32'(irq), 32'h0);
    for (int i = 0; i < 4; i++) begin
      logic [31:0] r;
      r = $random(seed);
      bus(1, pse_pkg::ADDR_IRQ_MASK, r);
      bus(0, pse_pkg::ADDR_IRQ_MASK, 0); chk(q, {25'h0, r[6:0]});
    end
    bus(1, pse_pkg::ADDR_CTRL, 32'h1);
    meas(12'h000); chk(32'(outs), 32'h1);
    bus(1, pse_pkg::ADDR_POL, 32'h7);
    repeat (10) @(posedge clk);
    @(posedge clk) chk(32'(outs), 32'h6);
    bus(0, pse_pkg::ADDR_OUTS, 0); chk(q, 32'h6);
    bus(1, pse_pkg::ADDR_POL, 32'h0);
    bus(1, pse_pkg::ADDR_CTRL, 32'h23);
    sf <= 1'b0; run <= 1'b0; sequence_stop_point <= 1'b0; bottom_of_stroke <= 1'b0; top_of_stroke <= 1'b0; cyc <= 1'b1;
    meas(12'h003);
    nm <= 1'b0;
    meas(12'h203);
    nm <= 1'b1; part_in_place_input <= 1'b1;
    meas(12'h202);
    final_report();
  end
endmodule
`default_nettype wire
